// ---- src/ppsl_top.sv ----
// top: two programmed-I/O ports with fixed interrupt priority and
// the seven front-edge status indicators.
// assumes host bus decode logic on core_clk_i; status pins asynchronous.
`timescale 1ns/10ps
`default_nettype none
module ppsl_top #(
  parameter logic [ppsl_pkg::KW-1:0] TICK_CYCLES   = ppsl_pkg::KW'(ppsl_pkg::TICK_CYC),
  parameter logic [ppsl_pkg::TW-1:0] TIMEOUT_TICKS = ppsl_pkg::TW'(ppsl_pkg::ST_TIMEOUT_TK)
) (
  input  wire logic                      core_clk_i,
  input  wire logic                      rst_b_i,
  input  wire ppsl_pkg::ppsl_reg_req_s   reg_req_i,
  output logic      [ppsl_pkg::DW-1:0]   rd_data_o,
  input  wire ppsl_pkg::ppsl_pio_req_s   pio_req_i,
  output ppsl_pkg::ppsl_pio_rsp_s        pio_rsp_o,
  input  wire logic                      scsi_fault_i,
  input  wire logic                      scsi_bsy_i,
  input  wire logic                      burst_active_i,
  output logic      [ppsl_pkg::NLED-1:0] led_o
);
  import ppsl_pkg::*;

  ppsl_top_state_s q;
  ppsl_top_state_s d;

  logic [NPIN-1:0] pin_s;
  logic            tick;
  logic            phase;
  logic [NP-1:0]   hit;
  logic [NP-1:0]   fin;
  logic [NP-1:0]   clr;
  logic            scsi_run;
  logic            host_run;
  logic            scsi_fail;
  logic            host_fail;

  ppsl_sync u_sync (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .pin_i      ({burst_active_i, scsi_bsy_i, scsi_fault_i}),
    .val_o      (pin_s)
  );

  ppsl_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .tick_o     (tick),
    .phase_o    (phase)
  );

  always_comb begin
    d       = q;
    d.rdata = '0;
    fin     = '0;
    clr     = '0;

    // device code decode per port
    hit[0] = pio_req_i.cmd && (pio_req_i.code == q.code0);
    // equal codes resolve to port 0
    hit[1] = pio_req_i.cmd && (pio_req_i.code == q.code1) && !hit[0];

    // register writes
    if (reg_req_i.wr) begin
      unique case (reg_req_i.addr)
        REG_CODE0: begin
          d.code0 = reg_req_i.wdata[CW-1:0];
        end
        REG_CODE1: begin
          d.code1 = reg_req_i.wdata[CW-1:0];
        end
        REG_CTRL: begin
          d.ctrl = reg_req_i.wdata[CTW-1:0];
        end
        REG_PORT: begin
          // firmware finishes a command on a port
          fin = reg_req_i.wdata[NP-1:0];
        end
        default: begin
        end
      endcase
    end

    // interrupt acknowledge clears the presented port
    if (pio_req_i.ack && q.irq) begin
      clr[q.port] = 1'b1;
    end

    for (int i = 0; i < NP; i++) begin
      // busy: set by a new command, cleared when ready again
      if (hit[i]) begin
        d.busy[i] = 1'b1;
      end else if (fin[i]) begin
        d.busy[i] = 1'b0;
      end
      // done: set wins over acknowledge
      if (fin[i]) begin
        d.done[i] = 1'b1;
      end else if (clr[i]) begin
        d.done[i] = 1'b0;
      end
    end

    // fixed priority, port 0 ahead of the maintenance port
    d.irq  = |d.done;
    d.port = !d.done[0];

    // self-test timeouts
    scsi_fail = q.ctrl[CTRL_SCSI_FAIL];
    host_fail = q.ctrl[CTRL_HOST_FAIL];
    scsi_run  = !q.ctrl[CTRL_SCSI_PASS] && !scsi_fail;
    host_run  = !q.ctrl[CTRL_HOST_PASS] && !host_fail;
    if (tick && scsi_run && !q.scsi_to) begin
      if (q.scsi_cnt == TIMEOUT_TICKS - TW'(1)) begin
        d.scsi_to = 1'b1;
      end else begin
        d.scsi_cnt = q.scsi_cnt + TW'(1);
      end
    end
    if (tick && host_run && !q.host_to) begin
      if (q.host_cnt == TIMEOUT_TICKS - TW'(1)) begin
        d.host_to = 1'b1;
      end else begin
        d.host_cnt = q.host_cnt + TW'(1);
      end
    end

    // indicators, left to right
    if (scsi_fail) begin
      // three scsi indicators flash together
      d.led[LED_SCSI_TEST]  = phase;
      d.led[LED_SCSI_FAULT] = phase;
      d.led[LED_SCSI_BUSY]  = phase;
    end else begin
      // lit until pass, stays lit on timeout
      d.led[LED_SCSI_TEST]  = !q.ctrl[CTRL_SCSI_PASS];
      d.led[LED_SCSI_FAULT] = pin_s[PIN_FAULT];
      // bsy low in bus free and disconnect
      d.led[LED_SCSI_BUSY]  = pin_s[PIN_BSY];
    end
    if (q.ctrl[CTRL_DEBUG]) begin
      d.led[LED_HOST_TEST] = 1'b1;
    end else if (host_fail) begin
      d.led[LED_HOST_TEST] = phase;
    end else begin
      d.led[LED_HOST_TEST] = !q.ctrl[CTRL_HOST_PASS];
    end
    d.led[LED_BURST] = pin_s[PIN_BURST];
    d.led[LED_PORT0] = d.busy[0];
    d.led[LED_MAINT] = d.busy[1];

    // register reads, data in the following cycle
    if (reg_req_i.rd) begin
      unique case (reg_req_i.addr)
        REG_CODE0: begin
          d.rdata[CW-1:0] = q.code0;
        end
        REG_CODE1: begin
          d.rdata[CW-1:0] = q.code1;
        end
        REG_CTRL: begin
          d.rdata[CTW-1:0] = q.ctrl;
        end
        REG_PORT: begin
          d.rdata[PORT_BUSY +: NP] = q.busy;
          d.rdata[PORT_DONE +: NP] = q.done;
        end
        REG_STATUS: begin
          d.rdata[STAT_LED +: NLED] = q.led;
          d.rdata[STAT_SCSI_TO]     = q.scsi_to;
          d.rdata[STAT_HOST_TO]     = q.host_to;
        end
        default: begin
          d.rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q          <= '0;
      q.code0    <= CODE0_RST;
      q.code1    <= CODE1_RST;
      q.ctrl     <= CTRL_RST;
      q.port     <= 1'b1;
      q.led      <= LED_RST; // both test indicators lit from reset
    end else begin
      q <= d;
    end
  end

  assign rd_data_o      = q.rdata;
  assign pio_rsp_o.irq  = q.irq;
  assign pio_rsp_o.port = q.port;
  assign pio_rsp_o.busy = q.busy;
  assign pio_rsp_o.done = q.done;
  assign led_o          = q.led;
endmodule
`default_nettype wire

// ---- src/ppsl_pkg.sv ----
// package: constants, carriers and state records of the port priority
// and status indicator block; assumes a 100 MHz core clock
package ppsl_pkg;

  // clock and time base
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned TICK_US       = 1000;
  localparam int unsigned TICK_CYC      = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned ST_TIMEOUT_S  = 30;
  localparam int unsigned ST_TIMEOUT_TK = ST_TIMEOUT_S * 1_000_000 / TICK_US;
  localparam int unsigned FLASH_MS      = 250;
  localparam int unsigned FLASH_TK      = FLASH_MS * 1000 / TICK_US;

  // widths
  localparam int unsigned AW   = 3;
  localparam int unsigned DW   = 16;
  localparam int unsigned CW   = 6;
  localparam int unsigned TW   = 15;
  localparam int unsigned KW   = 17;
  localparam int unsigned FW   = 8;
  localparam int unsigned NP   = 2;
  localparam int unsigned NLED = 7;
  localparam int unsigned NPIN = 3;
  localparam int unsigned CTW  = 5;

  // register offsets
  localparam logic [AW-1:0] REG_CODE0  = 3'h0;
  localparam logic [AW-1:0] REG_CODE1  = 3'h1;
  localparam logic [AW-1:0] REG_CTRL   = 3'h2;
  localparam logic [AW-1:0] REG_PORT   = 3'h3;
  localparam logic [AW-1:0] REG_STATUS = 3'h4;

  // reset values
  localparam logic [CW-1:0]  CODE0_RST = 6'h10;
  localparam logic [CW-1:0]  CODE1_RST = 6'h11;
  localparam logic [CTW-1:0] CTRL_RST  = 5'h00;
  localparam logic [NLED-1:0] LED_RST  = 7'h09;

  // control register fields
  localparam int unsigned CTRL_SCSI_PASS = 0;
  localparam int unsigned CTRL_SCSI_FAIL = 1;
  localparam int unsigned CTRL_HOST_PASS = 2;
  localparam int unsigned CTRL_HOST_FAIL = 3;
  localparam int unsigned CTRL_DEBUG     = 4;

  // port register fields
  localparam int unsigned PORT_BUSY = 0;
  localparam int unsigned PORT_DONE = 2;

  // status register fields
  localparam int unsigned STAT_LED     = 0;
  localparam int unsigned STAT_SCSI_TO = 8;
  localparam int unsigned STAT_HOST_TO = 9;

  // indicator positions, left to right
  localparam int unsigned LED_SCSI_TEST  = 0;
  localparam int unsigned LED_SCSI_FAULT = 1;
  localparam int unsigned LED_SCSI_BUSY  = 2;
  localparam int unsigned LED_HOST_TEST  = 3;
  localparam int unsigned LED_BURST      = 4;
  localparam int unsigned LED_PORT0      = 5;
  localparam int unsigned LED_MAINT      = 6;

  // pin input positions
  localparam int unsigned PIN_FAULT = 0;
  localparam int unsigned PIN_BSY   = 1;
  localparam int unsigned PIN_BURST = 2;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic          wr;
    logic          rd;
  } ppsl_reg_req_s;

  typedef struct packed {
    logic          cmd;
    logic [CW-1:0] code;
    logic          ack;
  } ppsl_pio_req_s;

  typedef struct packed {
    logic          irq;
    logic          port;
    logic [NP-1:0] busy;
    logic [NP-1:0] done;
  } ppsl_pio_rsp_s;

  typedef struct packed {
    logic [NPIN-1:0] s1;
    logic [NPIN-1:0] s2;
    logic [NPIN-1:0] s3;
    logic [NPIN-1:0] val;
  } ppsl_sync_state_s;

  typedef struct packed {
    logic [KW-1:0] cnt;
    logic          tick;
    logic [FW-1:0] fcnt;
    logic          phase;
  } ppsl_tick_state_s;

  typedef struct packed {
    logic [CW-1:0]   code0;
    logic [CW-1:0]   code1;
    logic [CTW-1:0]  ctrl;
    logic [NP-1:0]   busy;
    logic [NP-1:0]   done;
    logic            irq;
    logic            port;
    logic [TW-1:0]   scsi_cnt;
    logic [TW-1:0]   host_cnt;
    logic            scsi_to;
    logic            host_to;
    logic [NLED-1:0] led;
    logic [DW-1:0]   rdata;
  } ppsl_top_state_s;

endpackage

// ---- src/ppsl_sync.sv ----
// three-stage synchroniser for the status pins
// assumes pins are asynchronous to core_clk_i
`timescale 1ns/10ps
`default_nettype none
module ppsl_sync (
  input  wire logic                     core_clk_i,
  input  wire logic                     rst_b_i,
  input  wire logic [ppsl_pkg::NPIN-1:0] pin_i,
  output logic      [ppsl_pkg::NPIN-1:0] val_o
);
  import ppsl_pkg::*;

  ppsl_sync_state_s q;
  ppsl_sync_state_s d;
  logic [NPIN-1:0]  val_nxt;

  // accept a change once stages two and three agree
  for (genvar i = 0; i < NPIN; i++) begin : g_bit
    assign val_nxt[i] = (q.s2[i] == q.s3[i]) ? q.s3[i] : q.val[i];
  end

  always_comb begin
    d     = q;
    d.s1  = pin_i;
    d.s2  = q.s1;
    d.s3  = q.s2;
    d.val = val_nxt;
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign val_o = q.val;
endmodule
`default_nettype wire

// ---- src/ppsl_tick.sv ----
// time base: one-cycle tick enable and indicator flash phase
// assumes a free running core clock
`timescale 1ns/10ps
`default_nettype none
module ppsl_tick #(
  parameter logic [ppsl_pkg::KW-1:0] TICK_CYCLES = ppsl_pkg::KW'(ppsl_pkg::TICK_CYC)
) (
  input  wire logic core_clk_i,
  input  wire logic rst_b_i,
  output logic      tick_o,
  output logic      phase_o
);
  import ppsl_pkg::*;

  ppsl_tick_state_s q;
  ppsl_tick_state_s d;

  always_comb begin
    d      = q;
    d.tick = 1'b0;
    if (q.cnt == TICK_CYCLES - KW'(1)) begin
      d.cnt  = '0;
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt + KW'(1);
    end
    // flash phase toggles every flash period
    if (q.tick) begin
      if (q.fcnt == FW'(FLASH_TK - 1)) begin
        d.fcnt  = '0;
        d.phase = !q.phase;
      end else begin
        d.fcnt = q.fcnt + FW'(1);
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick_o  = q.tick;
  assign phase_o = q.phase;
endmodule
`default_nettype wire

// ---- sim/ppsl_host_model.sv ----
// host model: issues pio commands and acknowledges interrupts
// assumes command requests come from the bench on core_clk_i
`timescale 1ns/10ps
`default_nettype none
module ppsl_host_model (
  input  wire logic                    core_clk_i,
  input  wire logic                    rst_b_i,
  input  wire logic                    send_i,
  input  wire logic [ppsl_pkg::CW-1:0] code_i,
  input  wire ppsl_pkg::ppsl_pio_rsp_s rsp_i,
  output ppsl_pkg::ppsl_pio_req_s      req_o
);
  import ppsl_pkg::*;
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      req_o <= '0;
    end else begin
      req_o.cmd  <= send_i;
      // code lines toggle while not qualified
      req_o.code <= send_i ? code_i : ~req_o.code;
      // services the presented port, one at a time
      req_o.ack  <= rsp_i.irq && !req_o.ack;
    end
  end
endmodule
`default_nettype wire

// ---- sim/ppsl_top_props.sv ----
// checker: port priority and indicator relations at the top ports
// assumes bind into ppsl_top on the core clock
`timescale 1ns/10ps
`default_nettype none
module ppsl_top_props #(
  parameter logic [ppsl_pkg::KW-1:0] TICK_CYCLES   = ppsl_pkg::KW'(ppsl_pkg::TICK_CYC),
  parameter logic [ppsl_pkg::TW-1:0] TIMEOUT_TICKS = ppsl_pkg::TW'(ppsl_pkg::ST_TIMEOUT_TK)
) (
  input wire logic                      core_clk_i,
  input wire logic                      rst_b_i,
  input wire ppsl_pkg::ppsl_reg_req_s   reg_req_i,
  input wire logic [ppsl_pkg::DW-1:0]   rd_data_o,
  input wire ppsl_pkg::ppsl_pio_req_s   pio_req_i,
  input wire ppsl_pkg::ppsl_pio_rsp_s   pio_rsp_o,
  input wire logic                      scsi_fault_i,
  input wire logic                      scsi_bsy_i,
  input wire logic                      burst_active_i,
  input wire logic [ppsl_pkg::NLED-1:0] led_o
);
  import ppsl_pkg::*;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  property p_busy_led;
    led_o[LED_PORT0] == pio_rsp_o.busy[0] && led_o[LED_MAINT] == pio_rsp_o.busy[1];
  endproperty
  property p_busy_src;
    $rose(pio_rsp_o.busy[0]) || $rose(pio_rsp_o.busy[1]) |-> $past(pio_req_i.cmd);
  endproperty
  property p_prio;
    pio_rsp_o.port == !pio_rsp_o.done[0];
  endproperty
  property p_irq;
    pio_rsp_o.irq == (|pio_rsp_o.done);
  endproperty
  property p_fault;
    ($stable(scsi_fault_i) && !led_o[LED_SCSI_TEST])[*8] |-> led_o[LED_SCSI_FAULT] == scsi_fault_i;
  endproperty
  property p_bsy;
    ($stable(scsi_bsy_i) && !led_o[LED_SCSI_TEST])[*8] |-> led_o[LED_SCSI_BUSY] == scsi_bsy_i;
  endproperty
  property p_burst;
    $stable(burst_active_i)[*8] |-> led_o[LED_BURST] == burst_active_i;
  endproperty
  property p_flash;
    $rose(led_o[LED_SCSI_TEST]) |-> led_o[LED_SCSI_FAULT] && led_o[LED_SCSI_BUSY];
  endproperty
  a_busy_led: assert property (p_busy_led) else $error("busy indicator mismatch");
  a_busy_src: assert property (p_busy_src) else $error("busy without command");
  a_prio: assert property (p_prio) else $error("wrong port presented");
  a_irq: assert property (p_irq) else $error("irq mismatch");
  a_fault: assert property (p_fault) else $error("fault indicator mismatch");
  a_bsy: assert property (p_bsy) else $error("bus busy indicator mismatch");
  a_burst: assert property (p_burst) else $error("burst indicator mismatch");
  a_flash: assert property (p_flash) else $error("scsi indicators not flashing together");
  c_both: cover property (&pio_rsp_o.done);
  c_flash: cover property ($rose(led_o[LED_SCSI_TEST]));
  c_burst: cover property (led_o[LED_BURST]);
endmodule
bind ppsl_top ppsl_top_props #(
  .TICK_CYCLES(TICK_CYCLES),
  .TIMEOUT_TICKS(TIMEOUT_TICKS)
) u_props (
  .core_clk_i(core_clk_i),
  .rst_b_i(rst_b_i),
  .reg_req_i(reg_req_i),
  .rd_data_o(rd_data_o),
  .pio_req_i(pio_req_i),
  .pio_rsp_o(pio_rsp_o),
  .scsi_fault_i(scsi_fault_i),
  .scsi_bsy_i(scsi_bsy_i),
  .burst_active_i(burst_active_i),
  .led_o(led_o)
);
`default_nettype wire

// ---- sim/test_port_priority_status_leds.sv ----
// testbench: register tasks, host model and indicator checks
// assumes short tick and timeout counts in the design
`timescale 1ns/10ps
`default_nettype none
module test_port_priority_status_leds;
  import ppsl_pkg::*;
  logic            clk;
  logic            rst_b;
  ppsl_reg_req_s   rq;
  logic [DW-1:0]   rdat;
  ppsl_pio_req_s   pq;
  ppsl_pio_rsp_s   ps;
  logic            flt;
  logic            bsy;
  logic            bst;
  logic [NLED-1:0] led;
  logic            snd;
  logic [CW-1:0]   scode;
  logic [DW-1:0]   v;
  logic [1:0]      ack_seq = 2'b11;
  int              cyc = 0;
  int              fail_count = 0;
  int              n_checks = 0;
  int              n_on;
  int              n_h;
  int              n_bad;
  ppsl_top #(.TICK_CYCLES(KW'(4)), .TIMEOUT_TICKS(TW'(5))) u_dut (
    .core_clk_i(clk), .rst_b_i(rst_b), .reg_req_i(rq), .rd_data_o(rdat),
    .pio_req_i(pq), .pio_rsp_o(ps), .scsi_fault_i(flt), .scsi_bsy_i(bsy),
    .burst_active_i(bst), .led_o(led));
  ppsl_host_model u_host (
    .core_clk_i(clk), .rst_b_i(rst_b), .send_i(snd), .code_i(scode),
    .rsp_i(ps), .req_o(pq));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (pq.ack === 1'b1 && ps.irq === 1'b1) begin
      ack_seq <= {ack_seq[0], ps.port};
    end
    if (cyc == 8000) begin
      fail_count++;
      complete_run();
    end
  end
  task automatic chk(input string nm, input logic [DW-1:0] e, input logic [DW-1:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk);
    rq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    rq.wr <= 1'b0;
  endtask
  task automatic rd(input logic [AW-1:0] a);
    @(posedge clk);
    rq <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    rq.rd <= 1'b0;
    #1 v = rdat;
  endtask
  task automatic pio(input logic [CW-1:0] c);
    @(posedge clk);
    snd <= 1'b1;
    scode <= c;
    @(posedge clk);
    snd <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic pin(input logic [2:0] p);
    @(posedge clk);
    {bst, bsy, flt} <= p;
    repeat (10) @(posedge clk);
    #1;
  endtask
  initial begin
    rst_b = 0;
    rq = '0;
    {flt, bsy, bst, snd} = 4'h0;
    scode = '0;
    repeat (5) @(posedge clk);
    #1 chk("reset led", 16'h0009, 16'(led));
    repeat (15) @(posedge clk);
    rst_b <= 1;
    repeat (40) @(posedge clk);
    rd(REG_STATUS); chk("timeout", 16'h0309, v);
    rd(REG_CODE0); chk("code0", 16'(CODE0_RST), v);
    rd(REG_CODE1); chk("code1", 16'(CODE1_RST), v);
    @(posedge clk);
    #1 chk("rdata idle", 16'h0000, rdat);
    rd(3'h5); chk("unmapped", 16'h0000, v);
    pio(6'h22); chk("bad code", 16'h0000, 16'(ps.busy));
    pio(CODE0_RST); chk("busy0", 16'h0001, 16'(ps.busy));
    pio(CODE1_RST); chk("busy led", 16'h0060, 16'(led & 7'h60));
    rd(REG_PORT); chk("port reg", 16'h0003, v);
    wr(REG_PORT, 16'h0003);
    repeat (8) @(posedge clk);
    #1 chk("ack order", 16'h0001, 16'(ack_seq));
    chk("finished", 16'h0000, 16'({ps.busy, ps.done, ps.irq}));
    wr(REG_CODE0, 16'h0005);
    pio(6'h05); chk("new code", 16'h0001, 16'(ps.busy));
    wr(REG_PORT, 16'h0001);
    wr(REG_CTRL, 16'h0005);
    repeat (2) @(posedge clk);
    #1 chk("pass", 16'h0000, 16'(led & 7'h09));
    for (int i = 0; i < 3; i++) begin
      pin(3'(1 << i));
      chk("pin led", 16'(7'h02 << (i + (i == 2))), 16'(led & 7'h16));
    end
    pin(3'h0); chk("pins off", 16'h0000, 16'(led & 7'h16));
    wr(REG_CTRL, 16'h0015);
    rd(REG_STATUS); chk("debug", 16'h0008, v & 16'h007F);
    rst_b <= 0;
    repeat (3) @(posedge clk);
    rst_b <= 1;
    wr(REG_CTRL, 16'h000A);
    {n_on, n_h, n_bad} = '0;
    repeat (2400) begin
      @(posedge clk);
      #1;
      if (led[0] === 1'b1) n_on++;
      if (led[3] === 1'b1) n_h++;
      if (led[2:0] !== 3'b000 && led[2:0] !== 3'b111) n_bad++;
    end
    chk("flash together", 16'h0000, 16'(n_bad));
    chk("scsi flash", 16'h0001, 16'(n_on > 0 && n_on < 2400));
    chk("host flash", 16'h0001, 16'(n_h > 0 && n_h < 2400));
    complete_run();
  end
endmodule
`default_nettype wire
